// *** dv/fetx_mac_model.sv ***
`timescale 1ns/1ps
// ==========================================
// mac side model: runs the mii transmit clock and hands out queued nibbles
module fetx_mac_model (
    // clock and run control
    input wire logic clk_i,
    input wire logic run_i,
    // mii transmit toward the encoder
    output logic tx_clk_o,
    output fetx_pkg::fetx_mii_tx_t mii_tx_o,
    // status
    output logic busy_o
);
    logic [4:0] slot_q[$];
    int half_cnt = 0;

    // quiet start, clock parked low until run
    initial begin
        tx_clk_o = 1'b0;
        mii_tx_o = '0;
        busy_o = 1'b0;
    end

    // queue one nibble and its error flag for a later slot
    task automatic push(input logic [3:0] nib, input logic er);
        slot_q.push_back({er, nib});
        busy_o = 1'b1;
    endtask : push

    // the mii clock runs free so the encoder gets idle slots between frames;
    // 48 ns period is six system clock periods per phase
    always @(negedge clk_i) begin
        if (run_i) begin
            half_cnt = (half_cnt + 1) % 6;
            if (half_cnt == 0) begin
                tx_clk_o = ~tx_clk_o;
                if (tx_clk_o) begin
                    if (slot_q.size() > 0) begin
                        {mii_tx_o.er, mii_tx_o.data} = slot_q.pop_front();
                        mii_tx_o.en = 1'b1;
                    end else begin
                        // released data must not look like the last nibble
                        mii_tx_o.en = 1'b0;
                        mii_tx_o.er = 1'b0;
                        mii_tx_o.data = ~mii_tx_o.data;
                    end
                    busy_o = mii_tx_o.en;
                end
            end
        end
    end
endmodule : fetx_mac_model

// *** dv/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
    // ==========================================
    // stimulus and observed signals
    localparam logic [3:0] STRAPS = 4'hA;
    localparam logic PORT_IDX = 1'b1;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic soft_reset_i = 1'b0;
    logic scrambler_bypass_i = 1'b1;
    logic [4:0] rx_code_i = 5'h00;
    logic rx_code_valid_i = 1'b0;
    logic rx_in_frame_i = 1'b0;
    logic run = 1'b0;
    logic tx_clk, mac_busy, line_bit_strobe_o, rx_error_o, rx_valid_o;
    fetx_pkg::fetx_mii_tx_t mii_tx;
    fetx_pkg::fetx_mlt3_t mlt3_o;
    logic [4:0] port_address_o;
    logic [3:0] rx_nibble_o;
    int miscompares = 0;
    int total_checks = 0;
    // line monitor state: descrambler copy, nrzi level, driver side
    logic [10:0] lfsr_m;
    logic lvl_q, side_q, lvl, nb;
    logic bits_q[$];
    logic [4:0] enc_tbl [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
        5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};

    always #2 clk_i = ~clk_i;

    fetx_mac_model mac (.clk_i(clk_i), .run_i(run), .tx_clk_o(tx_clk), .mii_tx_o(mii_tx),
        .busy_o(mac_busy));

    fetx_tx_line_encoder dut (.clk_i(clk_i), .reset_i(reset_i), .tx_clk_i(tx_clk),
        .mii_tx_i(mii_tx), .port_address_strap_i(STRAPS), .port_index_i(PORT_IDX),
        .soft_reset_i(soft_reset_i), .scrambler_bypass_i(scrambler_bypass_i),
        .rx_code_i(rx_code_i), .rx_code_valid_i(rx_code_valid_i),
        .rx_in_frame_i(rx_in_frame_i), .mlt3_o(mlt3_o),
        .line_bit_strobe_o(line_bit_strobe_o), .port_address_o(port_address_o),
        .rx_nibble_o(rx_nibble_o), .rx_error_o(rx_error_o), .rx_valid_o(rx_valid_o));

    // ==========================================
    // reporting
    task automatic expect_true(input bit ok, input string msg);
        total_checks++;
        if (!ok) begin
            miscompares++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask : expect_true

    task automatic give_verdict();
        if (miscompares == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : give_verdict

    // ==========================================
    // line monitor: undo mlt-3, nrzi and scrambling at every bit strobe
    always @(negedge clk_i) begin
        if (reset_i) begin
            lfsr_m = {STRAPS, fetx_pkg::SEED_FILL};
            lvl_q = 1'b0;
            side_q = 1'b0;
        end else if (line_bit_strobe_o === 1'b1) begin
            lvl = mlt3_o.pos | mlt3_o.neg;
            if (lvl === 1'b1 && lvl_q === 1'b0) side_q = ~side_q;
            expect_true(mlt3_o === {lvl & ~side_q, lvl & side_q}, "driver side wrong");
            nb = lvl ^ lvl_q;
            bits_q.push_back(scrambler_bypass_i ? nb : nb ^ lfsr_m[10] ^ lfsr_m[8]);
            lfsr_m = {lfsr_m[9:0], lfsr_m[10] ^ lfsr_m[8]};
            lvl_q = lvl;
        end
    end

    function automatic logic [4:0] bits5(input int p);
        return {bits_q[p], bits_q[p+1], bits_q[p+2], bits_q[p+3], bits_q[p+4]};
    endfunction : bits5

    // {error, nibble} expected from the receive decoder
    function automatic logic [4:0] dec_exp(input logic [4:0] c, input logic fr);
        int n;
        for (n = 0; n < 16; n++) if (enc_tbl[n] == c) return {1'b0, 4'(n)};
        if (c == fetx_pkg::CG_IDLE || c == fetx_pkg::CG_T || c == fetx_pkg::CG_R)
            return {fr, 4'h0};
        if (c == fetx_pkg::CG_J || c == fetx_pkg::CG_K) return {fr, 4'h5};
        return 5'h10;
    endfunction : dec_exp

    // ==========================================
    // scenarios
    // one frame: two preamble nibbles, all sixteen data nibbles, optional error slot
    task automatic check_frame(input int er_at);
        logic [4:0] exp_q[$];
        int i;
        int j;
        int k;
        bits_q.delete();
        j = -1;
        exp_q = {fetx_pkg::CG_J, fetx_pkg::CG_K};
        mac.push(4'h5, 1'b0);
        mac.push(4'h5, 1'b0);
        for (i = 0; i < 16; i++) begin
            mac.push(4'(i), 1'(i == er_at));
            exp_q.push_back((i == er_at) ? fetx_pkg::CG_HALT : enc_tbl[i]);
        end
        exp_q.push_back(fetx_pkg::CG_T);
        exp_q.push_back(fetx_pkg::CG_R);
        exp_q.push_back(fetx_pkg::CG_IDLE);
        exp_q.push_back(fetx_pkg::CG_IDLE);
        for (k = 0; k < 1000 && !(j >= 0 && bits_q.size() >= j + 5 * exp_q.size()); k++) begin
            @(negedge clk_i);
            for (i = 0; j < 0 && i + 10 <= bits_q.size(); i++) begin
                if (bits5(i) == fetx_pkg::CG_J && bits5(i + 5) == fetx_pkg::CG_K) j = i;
            end
        end
        if (k == 1000) begin
            expect_true(1'b0, "frame never completed on the line");
            give_verdict();
        end
        for (i = 0; i < j; i++) expect_true(bits_q[i] === 1'b1, "idle broken");
        for (i = 0; i < exp_q.size(); i++) begin
            expect_true(bits5(j + 5 * i) === exp_q[i], "code-group wrong");
        end
        expect_true(mac_busy === 1'b0, "mac queue not drained");
    endtask : check_frame

    // every code-group in and out of a data field, back to back
    task automatic check_decode();
        int i;
        logic [4:0] e;
        for (i = 0; i <= 64; i++) begin
            @(negedge clk_i);
            if (i > 0) begin
                e = dec_exp(rx_code_i, rx_in_frame_i);
                expect_true(rx_valid_o === 1'b1 && {rx_error_o, rx_nibble_o} === e,
                    "decode wrong");
            end
            rx_code_i = 5'(i % 32);
            rx_in_frame_i = 1'(i >= 32);
            rx_code_valid_i = 1'(i < 64);
        end
        @(negedge clk_i);
        expect_true(rx_valid_o === 1'b0 && rx_error_o === 1'b0, "rx pulse too long");
    endtask : check_decode

    // partial reset, also used to switch scrambling on or off from a fresh seed
    task automatic do_soft_reset(input logic byp);
        @(negedge clk_i);
        scrambler_bypass_i = byp;
        soft_reset_i = 1'b1;
        @(negedge clk_i);
        soft_reset_i = 1'b0;
        expect_true(mlt3_o === 2'b00 && line_bit_strobe_o === 1'b0, "line not cleared");
        expect_true(port_address_o === {STRAPS, PORT_IDX}, "address lost");
        lfsr_m = {STRAPS, fetx_pkg::SEED_FILL};
        lvl_q = 1'b0;
        side_q = 1'b0;
    endtask : do_soft_reset

    // ==========================================
    // main sequence
    initial begin
        repeat (3) @(negedge clk_i);
        expect_true(mlt3_o === 2'b00 && port_address_o === 5'h00, "reset values wrong");
        reset_i = 1'b0;
        repeat (4) @(negedge clk_i);
        expect_true(port_address_o === {STRAPS, PORT_IDX}, "port address wrong");
        run = 1'b1;
        check_frame(-1);
        check_frame(5);
        check_decode();
        do_soft_reset(1'b0);
        check_frame(-1);
        do_soft_reset(1'b1);
        check_frame(15);
        give_verdict();
    end
endmodule : tb_top

// *** rtl/fetx_pkg.sv ***
// How it works
// R1 - each nibble maps to fixed 5-bit code-group
// R2 - idle 11111 between packets, decodes to 0000
// R3 - code-group 00100 is halt, a transmit error
// R4 - control code inside data field flags receive error
// R5 - J/K pair replaces first preamble byte
// R6 - enable dropping appends T/R end pair
// R7 - idles follow T/R until enable returns
// R8 - scrambler is closed-loop 11-bit LFSR
// R9 - scrambler bit XORed with serial code stream
// R10 - scrambler seed taken from address straps [4:1]
// R11 - bypass passes unscrambled stream to NRZI
// R12 - scrambled stream is NRZI encoded before MLT-3
// R13 - ones alternate between two driver streams
// R14 - line carries MLT-3 only, no binary mode
// R15 - nibbles become serial stream at 125 Mb/s
// R16 - sequencing follows the standard transmit state machine
// R17 - straps give address bits [4:1], port gives bit 0
// R18 - soft reset clears coding state, keeps configuration
// R19 - unknown code-group decodes as receive error
// R20 - NRZI toggles on one, holds on zero
package fetx_pkg;

    // ==========================================
    // code-groups
    localparam logic [4:0] CG_IDLE = 5'h1F;
    localparam logic [4:0] CG_J = 5'h18;
    localparam logic [4:0] CG_K = 5'h11;
    localparam logic [4:0] CG_T = 5'h0D;
    localparam logic [4:0] CG_R = 5'h07;
    localparam logic [4:0] CG_HALT = 5'h04;
    localparam logic [2:0] CG_BITS = 3'h5;
    localparam logic [3:0] NIB_PREAMBLE = 4'h5;
    localparam logic [3:0] NIB_ZERO = 4'h0;

    // ==========================================
    // timing: one line bit every BIT_CYCLES clocks
    localparam int CLK_PERIOD_PS = 4000;
    localparam int LINE_RATE_MBPS = 125;
    localparam int BIT_PERIOD_PS = 1000000 / LINE_RATE_MBPS;
    localparam int BIT_CYCLES = BIT_PERIOD_PS / CLK_PERIOD_PS;
    localparam logic [1:0] BIT_CNT_LAST = 2'(BIT_CYCLES - 1);
    localparam logic [1:0] STRAP_LATCH_CYCLES = 2'h3;

    // ==========================================
    // scrambler, x^11 + x^9 + 1
    localparam int LFSR_TAP_A = 10;
    localparam int LFSR_TAP_B = 8;
    localparam logic [10:0] LFSR_RESET = 11'h7FF;
    localparam logic [6:0] SEED_FILL = 7'h7F;

    // ==========================================
    // types
    typedef enum logic [1:0] {TX_IDLE, TX_SEND_K, TX_DATA, TX_SEND_R} fetx_tx_state_t;

    typedef struct packed {
        logic en;
        logic er;
        logic [3:0] data;
    } fetx_mii_tx_t;

    typedef struct packed {
        logic pos;
        logic neg;
    } fetx_mlt3_t;

    // data nibble to code-group, shared by encoder and decoder
    function automatic logic [4:0] fetx_encode(input logic [3:0] nib);
        logic [4:0] cg;
        cg = CG_IDLE;
        unique case (nib)
            4'h0: cg = 5'h1E;
            4'h1: cg = 5'h09;
            4'h2: cg = 5'h14;
            4'h3: cg = 5'h15;
            4'h4: cg = 5'h0A;
            4'h5: cg = 5'h0B;
            4'h6: cg = 5'h0E;
            4'h7: cg = 5'h0F;
            4'h8: cg = 5'h12;
            4'h9: cg = 5'h13;
            4'hA: cg = 5'h16;
            4'hB: cg = 5'h17;
            4'hC: cg = 5'h1A;
            4'hD: cg = 5'h1B;
            4'hE: cg = 5'h1C;
            4'hF: cg = 5'h1D;
        endcase
        return cg;
    endfunction : fetx_encode

endpackage : fetx_pkg

// *** rtl/fetx_rx_decoder.sv ***
`timescale 1ns/1ps
// ==========================================
// code-group to nibble lookup, purely combinational
module fetx_rx_decoder (
    // code-group in
    input wire logic [4:0] code_i,
    input wire logic in_frame_i,
    // nibble out
    output logic [3:0] nibble_o,
    output logic error_o
);

    // inverse of the shared encode table, then control and invalid codes
    always_comb begin
        logic hit;
        hit = 1'b0;
        nibble_o = fetx_pkg::NIB_ZERO;
        error_o = 1'b0;
        for (int i = 0; i < 16; i++) begin
            if (fetx_pkg::fetx_encode(4'(i)) == code_i) begin
                nibble_o = 4'(i); // R1
                hit = 1'b1;
            end
        end
        if (!hit) begin
            unique case (code_i)
                fetx_pkg::CG_IDLE, fetx_pkg::CG_T, fetx_pkg::CG_R: begin
                    nibble_o = fetx_pkg::NIB_ZERO; // R2
                    error_o = in_frame_i; // R4
                end
                fetx_pkg::CG_J, fetx_pkg::CG_K: begin
                    nibble_o = fetx_pkg::NIB_PREAMBLE;
                    error_o = in_frame_i; // R4
                end
                fetx_pkg::CG_HALT: begin
                    error_o = 1'b1; // R3
                end
                default: begin
                    error_o = 1'b1; // R19
                end
            endcase
        end
    end

endmodule : fetx_rx_decoder

// *** rtl/fetx_tx_line_encoder.sv ***
`timescale 1ns/1ps
module fetx_tx_line_encoder (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // MII transmit side, MAC clock domain
    input wire logic tx_clk_i,
    input wire fetx_pkg::fetx_mii_tx_t mii_tx_i,
    // address straps
    input wire logic [3:0] port_address_strap_i,
    input wire logic port_index_i,
    // control from same-clock logic
    input wire logic soft_reset_i,
    input wire logic scrambler_bypass_i,
    // receive code-groups from same-clock logic
    input wire logic [4:0] rx_code_i,
    input wire logic rx_code_valid_i,
    input wire logic rx_in_frame_i,
    // line side
    output fetx_pkg::fetx_mlt3_t mlt3_o,
    output logic line_bit_strobe_o,
    // status
    output logic [4:0] port_address_o,
    output logic [3:0] rx_nibble_o,
    output logic rx_error_o,
    output logic rx_valid_o
);

    // ==========================================
    // synchronisers: MII data and straps two flops each, MII clock three flops for its edge detect
    logic [2:0] tx_clk_r;
    fetx_pkg::fetx_mii_tx_t mii_meta_r;
    fetx_pkg::fetx_mii_tx_t mii_sync_r;
    logic [4:0] strap_meta_r;
    logic [4:0] strap_sync_r;
    logic nib_load;

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            tx_clk_r <= 3'h0;
            mii_meta_r <= '0;
            mii_sync_r <= '0;
            strap_meta_r <= 5'h00;
            strap_sync_r <= 5'h00;
        end else begin
            tx_clk_r <= {tx_clk_r[1:0], tx_clk_i};
            mii_meta_r <= mii_tx_i;
            mii_sync_r <= mii_meta_r;
            strap_meta_r <= {port_address_strap_i, port_index_i};
            strap_sync_r <= strap_meta_r;
        end
    end

    // take the nibble on the falling edge: the MAC launched it half a period earlier
    assign nib_load = tx_clk_r[2] & ~tx_clk_r[1];

    // ==========================================
    // strap latch, a few clocks after reset release
    logic [1:0] strap_cnt_r, strap_cnt_nxt;
    logic [4:0] strap_r, strap_nxt;
    logic strap_done;
    logic [10:0] seed;

    always_comb begin
        strap_cnt_nxt = strap_cnt_r;
        strap_nxt = strap_r;
        if (strap_cnt_r != fetx_pkg::STRAP_LATCH_CYCLES) begin
            strap_cnt_nxt = strap_cnt_r + 2'h1;
            strap_nxt = strap_sync_r;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            strap_cnt_r <= 2'h0;
            strap_r <= 5'h00;
        end else begin
            strap_cnt_r <= strap_cnt_nxt;
            strap_r <= strap_nxt;
        end
    end

    assign strap_done = (strap_cnt_r == fetx_pkg::STRAP_LATCH_CYCLES);
    assign port_address_o = strap_r; // R17
    // strap_r still reads zero on the latch edge, so seed from the value being latched
    assign seed = {strap_nxt[4:1], fetx_pkg::SEED_FILL}; // R10

    // ==========================================
    // code-group sequencer and serialiser
    fetx_pkg::fetx_tx_state_t state_r, state_nxt;
    logic [4:0] shift_r, shift_nxt;
    logic [2:0] bits_left_r, bits_left_nxt;
    logic [1:0] bit_cnt_r, bit_cnt_nxt;
    logic bit_strobe;
    logic [4:0] cg_next;

    assign bit_strobe = (bits_left_r != 3'h0) && (bit_cnt_r == fetx_pkg::BIT_CNT_LAST);

    // one code-group per MII nibble slot; state walk as in the standard machine
    always_comb begin
        state_nxt = state_r;
        cg_next = fetx_pkg::CG_IDLE; // R2 R7
        unique case (state_r) // R16
            fetx_pkg::TX_IDLE: begin
                if (mii_sync_r.en) begin
                    cg_next = fetx_pkg::CG_J; // R5
                    state_nxt = fetx_pkg::TX_SEND_K;
                end
            end
            fetx_pkg::TX_SEND_K: begin
                cg_next = fetx_pkg::CG_K; // R5
                state_nxt = fetx_pkg::TX_DATA;
            end
            fetx_pkg::TX_DATA: begin
                if (!mii_sync_r.en) begin
                    cg_next = fetx_pkg::CG_T; // R6
                    state_nxt = fetx_pkg::TX_SEND_R;
                end else if (mii_sync_r.er) begin
                    cg_next = fetx_pkg::CG_HALT; // R3
                end else begin
                    cg_next = fetx_pkg::fetx_encode(mii_sync_r.data); // R1
                end
            end
            fetx_pkg::TX_SEND_R: begin
                cg_next = fetx_pkg::CG_R; // R6
                state_nxt = fetx_pkg::TX_IDLE; // R7
            end
        endcase
    end

    // a bit due in the load cycle is sent first; a fast MAC clock drops the rest of the old code-group
    always_comb begin
        shift_nxt = shift_r;
        bits_left_nxt = bits_left_r;
        bit_cnt_nxt = bit_cnt_r + 2'h1;
        if (bit_cnt_r == fetx_pkg::BIT_CNT_LAST) begin
            bit_cnt_nxt = 2'h0;
        end
        if (bit_strobe) begin
            shift_nxt = {shift_r[3:0], 1'b0};
            bits_left_nxt = bits_left_r - 3'h1;
        end
        if (nib_load) begin
            shift_nxt = cg_next;
            bits_left_nxt = fetx_pkg::CG_BITS; // R15
            bit_cnt_nxt = 2'h0;
        end
        if (soft_reset_i) begin
            shift_nxt = fetx_pkg::CG_IDLE; // R18
            bits_left_nxt = 3'h0;
            bit_cnt_nxt = 2'h0;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            state_r <= fetx_pkg::TX_IDLE;
            shift_r <= fetx_pkg::CG_IDLE;
            bits_left_r <= 3'h0;
            bit_cnt_r <= 2'h0;
        end else begin
            state_r <= soft_reset_i ? fetx_pkg::TX_IDLE : (nib_load ? state_nxt : state_r);
            shift_r <= shift_nxt;
            bits_left_r <= bits_left_nxt;
            bit_cnt_r <= bit_cnt_nxt;
        end
    end

    // ==========================================
    // scrambler, NRZI and MLT-3 split, one step per line bit
    logic [10:0] lfsr_r, lfsr_nxt;
    logic nrzi_r, nrzi_nxt;
    logic side_r, side_nxt;
    logic prev_one_r, prev_one_nxt;
    logic strobe_r;
    fetx_pkg::fetx_mlt3_t mlt3_r, mlt3_nxt;
    logic lfsr_fb;
    logic scr_bit;

    assign lfsr_fb = lfsr_r[fetx_pkg::LFSR_TAP_A] ^ lfsr_r[fetx_pkg::LFSR_TAP_B]; // R8
    // bypass keeps the LFSR running so re-enabling needs no resync
    assign scr_bit = scrambler_bypass_i ? shift_r[4] : (shift_r[4] ^ lfsr_fb); // R9 R11

    always_comb begin
        lfsr_nxt = lfsr_r;
        nrzi_nxt = nrzi_r;
        side_nxt = side_r;
        prev_one_nxt = prev_one_r;
        mlt3_nxt = mlt3_r;
        if (!strap_done) begin
            lfsr_nxt = fetx_pkg::LFSR_RESET;
        end else if (bit_strobe) begin
            lfsr_nxt = {lfsr_r[9:0], lfsr_fb}; // R8
            nrzi_nxt = nrzi_r ^ scr_bit; // R12 R20
            // a new run of ones goes to the other driver side
            if (nrzi_nxt && !prev_one_r) begin
                side_nxt = ~side_r; // R13
            end
            prev_one_nxt = nrzi_nxt;
            mlt3_nxt.pos = nrzi_nxt & ~side_nxt; // R14
            mlt3_nxt.neg = nrzi_nxt & side_nxt; // R14
        end
        if (soft_reset_i || (strap_cnt_r == fetx_pkg::STRAP_LATCH_CYCLES - 2'h1)) begin
            lfsr_nxt = seed; // R10 R18
        end
        if (soft_reset_i) begin
            nrzi_nxt = 1'b0; // R18
            side_nxt = 1'b0;
            prev_one_nxt = 1'b0;
            mlt3_nxt = '0;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            lfsr_r <= fetx_pkg::LFSR_RESET;
            nrzi_r <= 1'b0;
            side_r <= 1'b0;
            prev_one_r <= 1'b0;
            mlt3_r <= '0;
            strobe_r <= 1'b0;
        end else begin
            lfsr_r <= lfsr_nxt;
            nrzi_r <= nrzi_nxt;
            side_r <= side_nxt;
            prev_one_r <= prev_one_nxt;
            mlt3_r <= mlt3_nxt;
            strobe_r <= bit_strobe & ~soft_reset_i;
        end
    end

    assign mlt3_o = mlt3_r;
    assign line_bit_strobe_o = strobe_r;

    // ==========================================
    // receive code-group decode, registered
    logic [3:0] dec_nibble;
    logic dec_error;
    logic [3:0] rx_nibble_r, rx_nibble_nxt;
    logic rx_error_r, rx_error_nxt;
    logic rx_valid_r, rx_valid_nxt;

    fetx_rx_decoder u_dec (
        .code_i(rx_code_i),
        .in_frame_i(rx_in_frame_i),
        .nibble_o(dec_nibble),
        .error_o(dec_error)
    );

    always_comb begin
        rx_nibble_nxt = rx_nibble_r;
        rx_error_nxt = 1'b0;
        rx_valid_nxt = 1'b0;
        if (rx_code_valid_i && !soft_reset_i) begin
            rx_nibble_nxt = dec_nibble; // R1
            rx_error_nxt = dec_error; // R4 R19
            rx_valid_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            rx_nibble_r <= fetx_pkg::NIB_ZERO;
            rx_error_r <= 1'b0;
            rx_valid_r <= 1'b0;
        end else begin
            rx_nibble_r <= rx_nibble_nxt;
            rx_error_r <= rx_error_nxt;
            rx_valid_r <= rx_valid_nxt;
        end
    end

    assign rx_nibble_o = rx_nibble_r;
    assign rx_error_o = rx_error_r;
    assign rx_valid_o = rx_valid_r;

    // ==========================================
    // assertions
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    logic slot;
    assign slot = nib_load & ~soft_reset_i;

    jk_start_a: assert property (slot && state_r == fetx_pkg::TX_IDLE && mii_sync_r.en // R5
        |=> shift_r == fetx_pkg::CG_J && state_r == fetx_pkg::TX_SEND_K)
        else $error("start pair not sent");
    k_second_a: assert property (slot && state_r == fetx_pkg::TX_SEND_K // R5
        |=> shift_r == fetx_pkg::CG_K && state_r == fetx_pkg::TX_DATA)
        else $error("second start code not sent");
    idle_fill_a: assert property (slot && state_r == fetx_pkg::TX_IDLE && !mii_sync_r.en // R2 R7
        |=> shift_r == fetx_pkg::CG_IDLE && state_r == fetx_pkg::TX_IDLE)
        else $error("idle not sent between packets");
    end_pair_a: assert property (slot && state_r == fetx_pkg::TX_DATA && !mii_sync_r.en // R6
        |=> shift_r == fetx_pkg::CG_T && state_r == fetx_pkg::TX_SEND_R)
        else $error("end pair not started");
    halt_code_a: assert property (slot && state_r == fetx_pkg::TX_DATA && mii_sync_r.en // R3
        && mii_sync_r.er |=> shift_r == fetx_pkg::CG_HALT)
        else $error("halt not sent on error");
    data_code_a: assert property (slot && state_r == fetx_pkg::TX_DATA && mii_sync_r.en // R1
        && !mii_sync_r.er |=> shift_r == fetx_pkg::fetx_encode($past(mii_sync_r.data)))
        else $error("wrong data code-group");
    bit_rate_a: assert property (bit_strobe |=> !bit_strobe) // R15
        else $error("line bits closer than one bit period");
    nrzi_step_a: assert property (bit_strobe && !soft_reset_i && strap_done // R20
        |=> nrzi_r == ($past(nrzi_r) ^ $past(scr_bit)))
        else $error("nrzi did not follow input bit");
    bypass_path_a: assert property (bit_strobe && scrambler_bypass_i && !soft_reset_i // R11
        && strap_done |=> strobe_r && nrzi_r == ($past(nrzi_r) ^ $past(shift_r[4])))
        else $error("bypass did not pass raw bit");
    mlt3_side_a: assert property (!(mlt3_o.pos && mlt3_o.neg)) // R13
        else $error("both driver sides active");
    seed_load_a: assert property (soft_reset_i |=> lfsr_r == seed && bits_left_r == 3'h0) // R18
        else $error("soft reset left coding state");
    rx_ctrl_a: assert property (rx_code_valid_i && !soft_reset_i && rx_in_frame_i // R4
        && rx_code_i == fetx_pkg::CG_IDLE |=> rx_error_o && rx_valid_o)
        else $error("idle in frame not flagged");

    frame_start_c: cover property (slot && state_r == fetx_pkg::TX_IDLE && mii_sync_r.en);
    frame_end_c: cover property (slot && state_r == fetx_pkg::TX_SEND_R);
    halt_c: cover property (slot && state_r == fetx_pkg::TX_DATA && mii_sync_r.er);
    bypass_c: cover property (bit_strobe && scrambler_bypass_i);

endmodule : fetx_tx_line_encoder
